// ===== shared/dbr_pkg.sv
// Functional notes
// - Registers are bytes within a 32-location address space.
// - Host gives start address in command byte; counter steps per byte.
// - Auto-increment stops once the command's count of registers is transferred.
// - Writes leave read-only bits unchanged; counter still steps past them.
// - Counter wraps from last implemented register back to address zero.
// - Both banks are readable and writable at any time.
// - Clear-on-access bits read current value, then clear on read or write.
// - Mirrored bank-B bits return the bank-A value, no separate storage.
// - Synthesiser unlock status is live, same in both banks.
// - Low-supply flag latches until any access of its register clears it.
// - Strobe oscillator enable writable only via bank A; bank B mirrors it.
// - Strength register returns the captured converter word, bank independent.
// - Bank indicator bit reads 1 for bank A active, 0 for bank B.
package dbr_pkg;

    // ----------------------------------------------------------------
    // Address map
    // ----------------------------------------------------------------
    localparam int         ADDR_W       = 5;
    localparam int         ADDR_SPACE   = 32;
    localparam int         REG_COUNT    = 4;
    localparam logic [4:0] OFS_FIRST    = 5'h00;
    localparam logic [4:0] OFS_BAND_A   = 5'h00;
    localparam logic [4:0] OFS_MODE_A   = 5'h01;
    localparam logic [4:0] OFS_FILTER_A = 5'h02;
    localparam logic [4:0] OFS_GAIN_A   = 5'h03;
    localparam logic [4:0] OFS_STRENGTH = 5'h0C;
    localparam logic [4:0] OFS_BAND_B   = 5'h0D;
    localparam logic [4:0] OFS_MODE_B   = 5'h0E;
    localparam logic [4:0] OFS_FILTER_B = 5'h0F;
    localparam logic [4:0] OFS_GAIN_B   = 5'h10;
    localparam logic [4:0] OFS_LAST     = 5'h10;

    // ----------------------------------------------------------------
    // Command byte layout
    // ----------------------------------------------------------------
    localparam int CMD_WRITE_BIT = 7;
    localparam int CMD_COUNT_HI  = 6;
    localparam int CMD_COUNT_LO  = 5;
    localparam int CMD_ADDR_HI   = 4;

    // ----------------------------------------------------------------
    // Register index within a bank, reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [1:0] IDX_BAND   = 2'h0;
    localparam logic [1:0] IDX_MODE   = 2'h1;
    localparam logic [1:0] IDX_FILTER = 2'h2;
    localparam logic [1:0] IDX_GAIN   = 2'h3;

    localparam logic [3:0][7:0] RST_REGS = {8'h09, 8'h30, 8'h10, 8'h91};
    localparam logic            RST_LOWSUP = 1'h1;

    localparam int BIT_RESET  = 3;
    localparam int BIT_SOE    = 0;
    localparam int BIT_UNLOCK = 5;
    localparam int BIT_LOWSUP = 4;
    localparam int BIT_BANKS  = 0;

    // Bits with plain storage that a write may change, per bank
    localparam logic [3:0][7:0] WMASK_A = {8'hFE, 8'hCF, 8'hFF, 8'hFF};
    localparam logic [3:0][7:0] WMASK_B = {8'hFE, 8'hCF, 8'hFE, 8'hF7};

    localparam int SYNC_W = 10;

    typedef logic [7:0] dbr_byte_type;

    typedef enum logic {
        DBR_IDLE,
        DBR_BURST
    } dbr_state_type;

endpackage

// ===== core/dbr_sync.sv
`timescale 1ns/1ps
module dbr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut_q
);

    logic [WIDTH-1:0] stage1_q;

    if (WIDTH < 1) begin : g_width_check
        $error("dbr_sync: WIDTH must be at least 1");
    end

    // ----------------------------------------------------------------
    // Two-stage synchroniser
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1_q  <= '0;
            syncOut_q <= '0;
        end else begin
            stage1_q  <= asyncIn;
            syncOut_q <= stage1_q;
        end
    end

endmodule

// ===== core/dbr_register_map.sv
`timescale 1ns/1ps
module dbr_register_map
    import dbr_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         cmdValid,
    input  wire logic [7:0]   cmdByte,
    input  wire logic         byteValid,
    input  wire logic [7:0]   byteData,
    input  wire logic         bankAActive,
    input  wire logic         synthUnlockIn,
    input  wire logic         lowSupplyIn,
    input  wire logic [7:0]   strengthIn,
    output logic              rdValid_q,
    output dbr_byte_type      rdData_q,
    output logic              burstActive_q,
    output logic [ADDR_W-1:0] curAddr_q,
    output dbr_byte_type      bandSetup_q,
    output dbr_byte_type      modeSetup_q,
    output dbr_byte_type      filterSetup_q,
    output dbr_byte_type      gainControl_q,
    output logic              strobeOscEnable_q,
    output logic              lowSupplyLatched_q
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    dbr_state_type              state_q;
    logic                       writeDir_q;
    logic [2:0]                 remain_q;
    logic [ADDR_W-1:0]          addr_q;
    dbr_byte_type               regA_q [REG_COUNT];
    dbr_byte_type               regB_q [REG_COUNT];
    logic                       lowSup_q;
    logic [SYNC_W-1:0]          syncBus;
    logic                       unlockS;
    logic                       lowSupS;
    dbr_byte_type               strengthS;
    dbr_byte_type               strengthPrev_q;
    dbr_byte_type               strengthHold_q;
    logic                       accessStb;
    logic                       writeStb;
    logic                       readStb;
    logic                       lastByte;
    logic [1:0]                 accIdx;
    logic                       accIsA;
    logic                       accIsB;
    logic                       lowSupClear;

    if (ADDR_SPACE != (1 << ADDR_W) || OFS_LAST >= ADDR_SPACE) begin : g_map_check
        $error("dbr_register_map: address map does not fit the address space");
    end

    if (REG_COUNT != 4) begin : g_count_check
        $error("dbr_register_map: bank index logic serves exactly four registers");
    end

    if (WMASK_B[IDX_BAND][BIT_RESET] != 1'b0) begin : g_reset_bit_check
        $error("dbr_register_map: bank-B copy of the soft reset bit must stay read-only");
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    dbr_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clk       (clk),
        .rst_b     (rst_b),
        .asyncIn   ({synthUnlockIn, lowSupplyIn, strengthIn}),
        .syncOut_q (syncBus)
    );

    assign unlockS   = syncBus[9];
    assign lowSupS   = syncBus[8];

    // ----------------------------------------------------------------
    // Strength word capture
    // ----------------------------------------------------------------
    // Converter bits may settle on different edges;
    // a word is taken once two synchronised samples agree
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strengthPrev_q <= 8'h00;
        end else begin
            strengthPrev_q <= syncBus[7:0];
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strengthHold_q <= 8'h00;
        end else if (strengthPrev_q == syncBus[7:0]) begin
            strengthHold_q <= strengthPrev_q;
        end
    end

    assign strengthS = strengthHold_q;

    // ----------------------------------------------------------------
    // Address decode helpers
    // ----------------------------------------------------------------
    function automatic logic isBankA(input logic [ADDR_W-1:0] a);
        isBankA = (a <= OFS_GAIN_A);
    endfunction

    function automatic logic isBankB(input logic [ADDR_W-1:0] a);
        isBankB = (a >= OFS_BAND_B) && (a <= OFS_GAIN_B);
    endfunction

    function automatic logic [1:0] regIndex(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] diff;
        diff = a - OFS_BAND_B;
        if (isBankB(a)) begin
            regIndex = diff[1:0];
        end else begin
            regIndex = a[1:0];
        end
    endfunction

    // Wrap after the last implemented location
    function automatic logic [ADDR_W-1:0] nextAddr(input logic [ADDR_W-1:0] a);
        if (a >= OFS_LAST) begin
            nextAddr = OFS_FIRST;
        end else begin
            nextAddr = a + 5'h01;
        end
    endfunction

    // ----------------------------------------------------------------
    // Read view of one location
    // ----------------------------------------------------------------
    function automatic dbr_byte_type readReg(input logic [ADDR_W-1:0] a);
        dbr_byte_type v;
        logic [1:0]   i;
        logic         inA;
        logic         inB;
        v   = 8'h00;
        i   = regIndex(a);
        inA = isBankA(a);
        inB = isBankB(a);
        if (inA) begin
            v = regA_q[i] & WMASK_A[i];
        end else if (inB) begin
            v = regB_q[i] & WMASK_B[i];
        end else if (a == OFS_STRENGTH) begin
            v = strengthS;
        end
        if ((inA || inB) && i == IDX_FILTER) begin
            v[BIT_UNLOCK] = unlockS;
            v[BIT_LOWSUP] = lowSup_q;
        end
        if ((inA || inB) && i == IDX_GAIN) begin
            v[BIT_BANKS] = bankAActive;
        end
        if (inB && i == IDX_MODE) begin
            v[BIT_SOE] = regA_q[IDX_MODE][BIT_SOE];
        end
        readReg = v;
    endfunction

    // ----------------------------------------------------------------
    // Access strobes
    // ----------------------------------------------------------------
    // A new command byte takes priority over a data byte in the same cycle
    assign accessStb   = (state_q == DBR_BURST) && byteValid && !cmdValid;
    assign writeStb    = accessStb && writeDir_q;
    assign readStb     = accessStb && !writeDir_q;
    assign lastByte    = (remain_q == 3'h1);
    assign accIdx      = regIndex(addr_q);
    assign accIsA      = isBankA(addr_q);
    assign accIsB      = isBankB(addr_q);
    assign lowSupClear = accessStb && (accIsA || accIsB) && (accIdx == IDX_FILTER);

    // ----------------------------------------------------------------
    // Burst sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q    <= DBR_IDLE;
            writeDir_q <= 1'b0;
            remain_q   <= 3'h0;
            addr_q     <= OFS_FIRST;
        end else begin
            if (cmdValid) begin
                state_q    <= DBR_BURST;
                writeDir_q <= cmdByte[CMD_WRITE_BIT];
                remain_q   <= {1'b0, cmdByte[CMD_COUNT_HI:CMD_COUNT_LO]} + 3'h1;
                addr_q     <= cmdByte[CMD_ADDR_HI:0];
            end else if (accessStb) begin
                remain_q <= remain_q - 3'h1;
                if (lastByte) begin
                    state_q <= DBR_IDLE;
                end else begin
                    addr_q <= nextAddr(addr_q);
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Bank storage
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int k = 0; k < REG_COUNT; k++) begin
                regA_q[k] <= RST_REGS[k];
                regB_q[k] <= RST_REGS[k];
            end
        end else if (writeStb) begin
            // Either bank, regardless of which is active
            if (accIsA) begin
                regA_q[accIdx] <= (regA_q[accIdx] & ~WMASK_A[accIdx]) | (byteData & WMASK_A[accIdx]);
            end else if (accIsB) begin
                regB_q[accIdx] <= (regB_q[accIdx] & ~WMASK_B[accIdx]) | (byteData & WMASK_B[accIdx]);
            end
        end
    end

    // ----------------------------------------------------------------
    // Latched low-supply flag, shared by both banks
    // ----------------------------------------------------------------
    // Set wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lowSup_q <= RST_LOWSUP;
        end else if (lowSupS) begin
            lowSup_q <= 1'b1;
        end else if (lowSupClear) begin
            lowSup_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Host read path
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdValid_q <= 1'b0;
        end else begin
            rdValid_q <= readStb;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdData_q <= 8'h00;
        end else if (readStb) begin
            rdData_q <= readReg(addr_q);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            burstActive_q <= 1'b0;
            curAddr_q     <= OFS_FIRST;
        end else begin
            burstActive_q <= (state_q == DBR_BURST);
            curAddr_q     <= addr_q;
        end
    end

    // ----------------------------------------------------------------
    // Active configuration towards the receiver
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bandSetup_q        <= RST_REGS[IDX_BAND];
            modeSetup_q        <= RST_REGS[IDX_MODE];
            filterSetup_q      <= RST_REGS[IDX_FILTER];
            gainControl_q      <= RST_REGS[IDX_GAIN];
        end else begin
            if (bankAActive) begin
                bandSetup_q   <= readReg(OFS_BAND_A);
                modeSetup_q   <= readReg(OFS_MODE_A);
                filterSetup_q <= readReg(OFS_FILTER_A);
                gainControl_q <= readReg(OFS_GAIN_A);
            end else begin
                bandSetup_q   <= readReg(OFS_BAND_B);
                modeSetup_q   <= readReg(OFS_MODE_B);
                filterSetup_q <= readReg(OFS_FILTER_B);
                gainControl_q <= readReg(OFS_GAIN_B);
            end
        end
    end

    // ----------------------------------------------------------------
    // Mirrored single-bit outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strobeOscEnable_q  <= RST_REGS[IDX_MODE][BIT_SOE];
            lowSupplyLatched_q <= RST_LOWSUP;
        end else begin
            strobeOscEnable_q  <= regA_q[IDX_MODE][BIT_SOE];
            lowSupplyLatched_q <= lowSup_q;
        end
    end

endmodule

// ===== tb/dbr_register_map_chk.sv
`timescale 1ns/1ps
module dbr_register_map_chk
    import dbr_pkg::*;
(
    input wire logic         clk,
    input wire logic         rst_b,
    input wire logic         cmdValid,
    input wire logic         byteValid,
    input wire logic         bankAActive,
    input wire logic         synthUnlockIn,
    input wire logic         lowSupplyIn,
    input wire logic         rdValid_q,
    input wire dbr_byte_type rdData_q,
    input wire logic         burstActive_q,
    input wire dbr_byte_type filterSetup_q,
    input wire dbr_byte_type gainControl_q,
    input wire logic         strobeOscEnable_q,
    input wire logic         lowSupplyLatched_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence unlockHigh; synthUnlockIn[*6]; endsequence
    sequence unlockLow; !synthUnlockIn[*6]; endsequence
    sequence supplyLow; lowSupplyIn[*5]; endsequence
    rd_cause_a: assert property (rdValid_q |-> $past(byteValid) && !$past(cmdValid))
        else $error("read pulse without byte request");
    data_hold_a: assert property (!rdValid_q |-> $stable(rdData_q))
        else $error("read data moved without read pulse");
    burst_start_a: assert property ($rose(burstActive_q) |-> $past(cmdValid) || $past(cmdValid, 2))
        else $error("burst began without command");
    unlock_high_a: assert property (unlockHigh |=> filterSetup_q[BIT_UNLOCK])
        else $error("unlock bit not following input");
    unlock_low_a: assert property (unlockLow |=> !filterSetup_q[BIT_UNLOCK])
        else $error("unlock bit stuck high");
    lowsup_set_a: assert property (supplyLow |=> lowSupplyLatched_q)
        else $error("low supply not latched");
    lowsup_clear_a: assert property ($fell(lowSupplyLatched_q) |->
        $past(byteValid) || $past(byteValid, 2) || $past(byteValid, 3))
        else $error("low supply flag cleared without access");
    soe_change_a: assert property ($changed(strobeOscEnable_q) |->
        $past(byteValid) || $past(byteValid, 2) || $past(byteValid, 3))
        else $error("strobe enable moved without write");
    bank_bit_a: assert property ($stable(bankAActive) |=> gainControl_q[BIT_BANKS] == $past(bankAActive))
        else $error("bank bit wrong");
endmodule

// ===== tb/dbr_host_model.sv
`timescale 1ns/1ps
module dbr_host_model (
    input  wire logic       clk,
    input  wire logic       rdValid_q,
    input  wire logic [7:0] rdData_q,
    output logic            cmdValid,
    output logic [7:0]      cmdByte,
    output logic            byteValid,
    output logic [7:0]      byteData
);
    logic [7:0] rdQ[$];
    initial begin
        cmdValid = 1'b0;
        cmdByte = 8'h00;
        byteValid = 1'b0;
        byteData = 8'h00;
    end
    always @(posedge clk) begin
        if (rdValid_q === 1'b1) begin
            rdQ.push_back(rdData_q);
        end
    end
    // Command then N+1 bytes back to back; released lines show inverse
    task automatic xfer(input logic [7:0] cmd, input logic [31:0] wd);
        int n;
        n = int'(cmd[6:5]);
        rdQ.delete();
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdByte <= cmd;
        for (int i = 0; i <= n; i++) begin
            @(posedge clk);
            cmdValid <= 1'b0;
            byteValid <= 1'b1;
            byteData <= wd[8*i +: 8];
        end
        @(posedge clk);
        byteValid <= 1'b0;
        cmdByte <= ~cmd;
        byteData <= ~byteData;
        repeat (3) @(posedge clk);
    endtask
endmodule

// ===== tb/dbr_register_map_tb.sv
`timescale 1ns/1ps
module dbr_register_map_tb;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       bankAActive = 1'b1;
    logic       synthUnlockIn = 1'b0;
    logic       lowSupplyIn = 1'b0;
    logic [7:0] strengthIn = 8'h00;
    logic       cmdValid, byteValid, rdValid_q, burstActive_q, strobeOscEnable_q;
    logic [7:0] cmdByte, byteData, rdData_q;
    logic [4:0] curAddr_q;
    logic [7:0] bandSetup_q, modeSetup_q;
    logic       lowSupplyLatched_q;
    int         err_total = 0;
    int         tests_run = 0;
    always #5 clk = ~clk;
    dbr_host_model host (.clk(clk), .rdValid_q(rdValid_q), .rdData_q(rdData_q), .cmdValid(cmdValid),
        .cmdByte(cmdByte), .byteValid(byteValid), .byteData(byteData));
    dbr_register_map dut (.clk(clk), .rst_b(rst_b), .cmdValid(cmdValid), .cmdByte(cmdByte),
        .byteValid(byteValid), .byteData(byteData), .bankAActive(bankAActive),
        .synthUnlockIn(synthUnlockIn), .lowSupplyIn(lowSupplyIn), .strengthIn(strengthIn),
        .rdValid_q(rdValid_q), .rdData_q(rdData_q), .burstActive_q(burstActive_q), .curAddr_q(curAddr_q),
        .bandSetup_q(bandSetup_q), .modeSetup_q(modeSetup_q), .filterSetup_q(), .gainControl_q(),
        .strobeOscEnable_q(strobeOscEnable_q), .lowSupplyLatched_q(lowSupplyLatched_q));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [31:0] exp);
        host.xfer(cmd, 32'h0000_0000);
        chk("read count", 8'(cmd[6:5]) + 8'h01, 8'(host.rdQ.size()));
        for (int i = 0; i <= int'(cmd[6:5]); i++) begin
            chk("read data", exp[8*i +: 8], host.rdQ[i]);
        end
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rd(8'h60, 32'h0910_1091);
        rd(8'h02, 32'h0000_0000);
        $display("test reset values done");
    endtask
    task automatic t_wrap();
        host.xfer(8'hEF, 32'h015A_FFFF);
        chk("address hold", 8'h01, {3'h0, curAddr_q});
        chk("strobe enable", 8'h01, {7'h00, strobeOscEnable_q});
        chk("band view", 8'h5A, bandSetup_q);
        chk("mode view", 8'h01, modeSetup_q);
        rd(8'h6F, 32'h015A_FFCF);
        host.xfer(8'hAD, 32'h0000_00FF);
        rd(8'h2D, 32'h0000_01F7);
        chk("strobe enable", 8'h01, {7'h00, strobeOscEnable_q});
        $display("test wrap and mirrors done");
    endtask
    task automatic t_restart();
        @(posedge clk);
        host.rdQ.delete();
        host.cmdValid <= 1'b1;
        host.cmdByte  <= 8'h81;
        @(posedge clk);
        host.cmdByte   <= 8'h00;
        host.byteValid <= 1'b1;
        host.byteData  <= 8'h33;
        @(posedge clk);
        host.cmdValid <= 1'b0;
        repeat (2) @(posedge clk);
        host.byteValid <= 1'b0;
        repeat (3) @(posedge clk);
        chk("restart count", 8'h01, 8'(host.rdQ.size()));
        chk("restart data", 8'h5A, host.rdQ[0]);
        chk("restart address", 8'h00, {3'h0, curAddr_q});
        rd(8'h01, 32'h0000_0001);
        $display("test command restart done");
    endtask
    task automatic t_live();
        synthUnlockIn <= 1'b1;
        lowSupplyIn <= 1'b1;
        strengthIn <= 8'hA5;
        repeat (8) @(posedge clk);
        lowSupplyIn <= 1'b0;
        repeat (4) @(posedge clk);
        chk("low supply flag", 8'h01, {7'h00, lowSupplyLatched_q});
        rd(8'h6C, 32'hFF01_F7A5);
        rd(8'h02, 32'h0000_0020);
        chk("low supply flag", 8'h00, {7'h00, lowSupplyLatched_q});
        $display("test live bits done");
    endtask
    task automatic t_bank();
        bankAActive <= 1'b0;
        rd(8'h03, 32'h0000_0008);
        rd(8'h4C, 32'h0001_F7A5);
        chk("band view", 8'hF7, bandSetup_q);
        chk("mode view", 8'h01, modeSetup_q);
        host.xfer(8'h85, 32'h0000_00FF);
        rd(8'h05, 32'h0000_0000);
        bankAActive <= 1'b1;
        rd(8'h10, 32'h0000_00FF);
        $display("test bank indicator done");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_wrap();
        t_restart();
        t_live();
        t_bank();
        report_and_stop();
    end
    initial begin
        repeat (3000) @(posedge clk);
        err_total++;
        report_and_stop();
    end
endmodule
bind dbr_register_map dbr_register_map_chk u_chk (.clk(clk), .rst_b(rst_b), .cmdValid(cmdValid),
    .byteValid(byteValid), .bankAActive(bankAActive), .synthUnlockIn(synthUnlockIn),
    .lowSupplyIn(lowSupplyIn), .rdValid_q(rdValid_q), .rdData_q(rdData_q), .burstActive_q(burstActive_q),
    .filterSetup_q(filterSetup_q), .gainControl_q(gainControl_q), .strobeOscEnable_q(strobeOscEnable_q),
    .lowSupplyLatched_q(lowSupplyLatched_q));
